// >>> core/epi_pkg.sv
// Package for the external pin interrupt block: register map, field layout,
// sense-mode encoding and the packed carriers shared by the design.
// Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
package epi_pkg;

    localparam int EPI_ADDR_W = 4;

    // Byte offsets of the registers on the bus
    localparam logic [EPI_ADDR_W-1:0] EPI_OFS_SENSE = 4'h0;
    localparam logic [EPI_ADDR_W-1:0] EPI_OFS_EN    = 4'h4;
    localparam logic [EPI_ADDR_W-1:0] EPI_OFS_FLAGS = 4'h8;
    localparam logic [EPI_ADDR_W-1:0] EPI_OFS_MASK  = 4'hC;

    // Reset values
    localparam logic [7:0] EPI_RST_SENSE = 8'h00;
    localparam logic [7:0] EPI_RST_EN    = 8'h00;
    localparam logic [7:0] EPI_RST_MASK  = 8'h00;

    // Field positions
    localparam int EPI_SENSE_A_LSB = 0;
    localparam int EPI_SENSE_B_LSB = 2;
    localparam int EPI_BIT_B       = 7;
    localparam int EPI_BIT_A       = 6;
    localparam int EPI_BIT_PC      = 5;
    localparam int EPI_BIT_EN_LSB0 = 0;

    // Writable bits of the enable register: both line enables, the pin-change enable and bit 0
    localparam logic [7:0] EPI_EN_WMASK = 8'hE1;

    typedef enum logic [1:0] {
        EPI_SENSE_LOW    = 2'b00,
        EPI_SENSE_CHANGE = 2'b01,
        EPI_SENSE_FALL   = 2'b10,
        EPI_SENSE_RISE   = 2'b11
    } epi_sense_t;

    typedef struct packed {
        logic [7:0] sense;
        logic [7:0] en;
        logic       flag_b;
        logic       flag_a;
        logic       flag_pc;
        logic [7:0] mask;
        logic [1:0] ext_s1;
        logic [1:0] ext_s2;
        logic [1:0] ext_prev;
        logic [31:0] rdata;
        logic       ack;
    } epi_state_t;

    typedef struct packed {
        logic irq_b;
        logic irq_a;
        logic irq_pc;
        logic irq_pc_hi;
        logic irq_pc_lo;
    } epi_req_t;

    typedef struct packed {
        logic ack_b;
        logic ack_a;
        logic ack_pc;
    } epi_iack_t;

endpackage

// >>> core/epi_ext_irq.sv
// External pin interrupt logic: two sense-selectable lines, sixteen pin-change
// lines grouped in two halves, enables, sticky flags and global gating.
// Assumes pins are asynchronous, the CPU supplies the global enable and a
// one-cycle acknowledge per vector, and a classic Wishbone master.
//
// Summary of operation
// - Requests come from pin levels regardless of the pin's direction.
// - Upper group request rises when any masked-in line 15..8 toggles.
// - Lower group request rises when any masked-in line 7..0 toggles.
// - Pin-change detection is combinational from pins, usable without a clock.
// - Level mode keeps the request high while the pin stays low.
// - Edge detection only works while the clock runs.
// - Low level is seen without a clock for wake-up.
// - Wake-up low level must be held through start-up or no interrupt.
// - Line b sense in bits 3:2: low, change, falling, rising.
// - Line a sense in bits 1:0 with the same encoding.
// - Lines sampled before edge detect; pulses over one clock are caught.
// - Line b interrupt needs enable bit 7 and global enable.
// - Line a interrupt needs enable bit 6 and global enable.
// - Pin-change enable bit 5 with global enable requests the pin-change vector.
// - Flag b sets on trigger, clears by acknowledge or write one, zero in level mode.
// - Flag a sets on trigger, clears by acknowledge or write one, zero in level mode.
// - Pin-change flag sets on masked lower change, clears by acknowledge or write one.
// - Each mask bit enables change detection on its own pin.
`timescale 1ns/100ps
`default_nettype none

module epi_ext_irq
    import epi_pkg::*;
#(
    parameter int PC_LINES = 16
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic                  clk_en,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [EPI_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // Pins and pin-change references
    input  wire logic                  ext_line_a,
    input  wire logic                  ext_line_b,
    input  wire logic [PC_LINES-1:0]   pin_change_lines,
    input  wire logic [PC_LINES-1:0]   pin_change_ref,
    input  wire logic [7:0]            pin_change_mask_hi,
    // CPU side
    input  wire logic                  global_irq_en,
    input  wire epi_iack_t             irq_ack,
    output epi_req_t                   irq_req,
    output logic                       wake_req
);

    // Elaboration check: the group split and the mask widths assume sixteen lines
    if (PC_LINES != 16) begin : g_bad_lines
        $error("epi_ext_irq: PC_LINES must be 16");
    end

    epi_state_t st;
    epi_state_t next_st;

    logic       wr_acc;
    logic       rd_acc;
    logic [1:0] ext_pins;
    logic [1:0] ext_sync;
    logic [1:0] ext_trig;
    logic       pc_lo_change;
    logic       pc_hi_change;
    logic       pc_lo_raw;
    logic       level_a;
    logic       level_b;

    // Trigger of one line under a sense mode; level mode never sets a flag
    function automatic logic edge_hit(input epi_sense_t m, input logic cur, input logic prev);
        logic r;
        r = 1'b0;
        unique case (m)
            EPI_SENSE_LOW:    r = 1'b0;
            EPI_SENSE_CHANGE: r = cur ^ prev;
            EPI_SENSE_FALL:   r = prev & ~cur;
            EPI_SENSE_RISE:   r = cur & ~prev;
        endcase
        return r;
    endfunction

    assign wr_acc   = wb_cyc_i & wb_stb_i & wb_we_i & ~st.ack & wb_sel_i[0];
    assign rd_acc   = wb_cyc_i & wb_stb_i & ~st.ack;
    assign ext_pins = {ext_line_b, ext_line_a};
    assign ext_sync = st.ext_s2;

    always_comb begin
        ext_trig[1] = edge_hit(epi_sense_t'(st.sense[EPI_SENSE_B_LSB +: 2]), ext_sync[1], st.ext_prev[1]);
        ext_trig[0] = edge_hit(epi_sense_t'(st.sense[EPI_SENSE_A_LSB +: 2]), ext_sync[0], st.ext_prev[0]);
    end

    // Pin-change compare against the port's last value is purely combinational
    assign pc_lo_change = |((pin_change_lines[7:0] ^ pin_change_ref[7:0]) & st.mask);
    assign pc_hi_change = |((pin_change_lines[15:8] ^ pin_change_ref[15:8]) & pin_change_mask_hi);
    assign pc_lo_raw    = pc_lo_change & st.en[EPI_BIT_PC];

    // Level requests read the raw pins so they work with the clock halted
    assign level_a = (epi_sense_t'(st.sense[EPI_SENSE_A_LSB +: 2]) == EPI_SENSE_LOW) & ~ext_line_a;
    assign level_b = (epi_sense_t'(st.sense[EPI_SENSE_B_LSB +: 2]) == EPI_SENSE_LOW) & ~ext_line_b;

    always_comb begin
        next_st = st;
        // Two-stage synchroniser then previous-sample register
        next_st.ext_s1   = ext_pins;
        next_st.ext_s2   = st.ext_s1;
        next_st.ext_prev = st.ext_s2;
        next_st.ack      = rd_acc;
        next_st.rdata    = 32'h0000_0000;

        if (wr_acc) begin
            unique case (wb_adr_i)
                EPI_OFS_SENSE: next_st.sense = wb_dat_i[7:0];
                EPI_OFS_EN:    next_st.en = wb_dat_i[7:0] & EPI_EN_WMASK;
                EPI_OFS_MASK:  next_st.mask = wb_dat_i[7:0];
                EPI_OFS_FLAGS: begin
                    if (wb_dat_i[EPI_BIT_B]) begin
                        next_st.flag_b = 1'b0;
                    end
                    if (wb_dat_i[EPI_BIT_A]) begin
                        next_st.flag_a = 1'b0;
                    end
                    if (wb_dat_i[EPI_BIT_PC]) begin
                        next_st.flag_pc = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (irq_ack.ack_b) begin
            next_st.flag_b = 1'b0;
        end
        if (irq_ack.ack_a) begin
            next_st.flag_a = 1'b0;
        end
        if (irq_ack.ack_pc) begin
            next_st.flag_pc = 1'b0;
        end
        // Setting wins over a simultaneous clear
        if (ext_trig[1]) begin
            next_st.flag_b = 1'b1;
        end
        if (ext_trig[0]) begin
            next_st.flag_a = 1'b1;
        end
        if (pc_lo_change) begin
            next_st.flag_pc = 1'b1;
        end
        // Level mode keeps the edge flags cleared
        if (epi_sense_t'(st.sense[EPI_SENSE_B_LSB +: 2]) == EPI_SENSE_LOW) begin
            next_st.flag_b = 1'b0;
        end
        if (epi_sense_t'(st.sense[EPI_SENSE_A_LSB +: 2]) == EPI_SENSE_LOW) begin
            next_st.flag_a = 1'b0;
        end

        if (rd_acc) begin
            unique case (wb_adr_i)
                EPI_OFS_SENSE: next_st.rdata[7:0] = st.sense;
                EPI_OFS_EN:    next_st.rdata[7:0] = st.en;
                EPI_OFS_MASK:  next_st.rdata[7:0] = st.mask;
                EPI_OFS_FLAGS: begin
                    next_st.rdata[EPI_BIT_B]  = st.flag_b;
                    next_st.rdata[EPI_BIT_A]  = st.flag_a;
                    next_st.rdata[EPI_BIT_PC] = st.flag_pc;
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st         <= '0;
            st.sense   <= EPI_RST_SENSE;
            st.en      <= EPI_RST_EN;
            st.mask    <= EPI_RST_MASK;
            st.ext_s1  <= 2'b11;
            st.ext_s2  <= 2'b11;
            st.ext_prev <= 2'b11;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;

    // Line and pin-change vector requests gated by own enable and the global enable; the two group requests are not
    always_comb begin
        irq_req.irq_b     = global_irq_en & st.en[EPI_BIT_B] & (st.flag_b | level_b);
        irq_req.irq_a     = global_irq_en & st.en[EPI_BIT_A] & (st.flag_a | level_a);
        irq_req.irq_pc    = global_irq_en & st.en[EPI_BIT_PC] & st.flag_pc;
        irq_req.irq_pc_hi = pc_hi_change;
        irq_req.irq_pc_lo = pc_lo_change;
    end

    // Clockless wake: a held low level or a masked lower-group pin change; a level dropped
    // before start-up ends wakes but leaves no request
    assign wake_req = (st.en[EPI_BIT_B] & level_b) | (st.en[EPI_BIT_A] & level_a) | pc_lo_raw;

    // Level request checked against the raw pin, not the internal level term
    property p_level_a;
        @(posedge clk) disable iff (!nrst)
        (global_irq_en && st.en[EPI_BIT_A] && st.sense[EPI_SENSE_A_LSB +: 2] == 2'b00 && !ext_line_a)
            |-> irq_req.irq_a;
    endproperty
    level_req_a_a: assert property (p_level_a) else $error("level request a missing");

    rise_sets_b_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[3:2] == 2'b11 && st.ext_s2[1] && !st.ext_prev[1]) |=> st.flag_b)
        else $error("rising edge did not set flag b");

    fall_sets_a_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[1:0] == 2'b10 && !st.ext_s2[0] && st.ext_prev[0]) |=> st.flag_a)
        else $error("falling edge did not set flag a");

    level_flag_b_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[3:2] == 2'b00) |=> !st.flag_b)
        else $error("flag b set in level mode");

    ack_clear_a_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && irq_ack.ack_a && !ext_trig[0]) |=> !st.flag_a)
        else $error("acknowledge did not clear flag a");

    pc_flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && pc_lo_change) |=> st.flag_pc)
        else $error("pin change flag not set");

    gate_b_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_req.irq_b |-> (global_irq_en && st.en[EPI_BIT_B]))
        else $error("line b request without enables");

    gate_pc_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_req.irq_pc |-> (global_irq_en && st.en[EPI_BIT_PC] && st.flag_pc))
        else $error("pin change request without enables");

    sync_chain_a: assert property (@(posedge clk) disable iff (!nrst)
        clk_en ##1 clk_en |=> st.ext_prev == $past(st.ext_s1, 2))
        else $error("synchroniser chain broken");

    mask_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        (st.mask == 8'h00) |-> !pc_lo_change)
        else $error("pin change with empty mask");

    ack_single_a: assert property (@(posedge clk) disable iff (!nrst)
        (wb_ack_o && clk_en) |=> !wb_ack_o)
        else $error("bus ack held two cycles");

    level_req_b_a: assert property (@(posedge clk) disable iff (!nrst)
        (global_irq_en && st.en[EPI_BIT_B] && st.sense[EPI_SENSE_B_LSB +: 2] == 2'b00 && !ext_line_b)
            |-> irq_req.irq_b)
        else $error("level request b missing");

    gate_a_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_req.irq_a |-> (global_irq_en && st.en[EPI_BIT_A]))
        else $error("line a request without enables");

    rise_sets_a_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[1:0] == 2'b11 && st.ext_s2[0] && !st.ext_prev[0]) |=> st.flag_a)
        else $error("rising edge did not set flag a");

    fall_sets_b_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[3:2] == 2'b10 && !st.ext_s2[1] && st.ext_prev[1]) |=> st.flag_b)
        else $error("falling edge did not set flag b");

    change_sets_a_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[1:0] == 2'b01 && st.ext_s2[0] != st.ext_prev[0]) |=> st.flag_a)
        else $error("change did not set flag a");

    level_flag_a_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && st.sense[1:0] == 2'b00) |=> !st.flag_a)
        else $error("flag a set in level mode");

    ack_clear_b_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && irq_ack.ack_b && !ext_trig[1]) |=> !st.flag_b)
        else $error("acknowledge did not clear flag b");

    ack_clear_pc_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && irq_ack.ack_pc && !pc_lo_change) |=> !st.flag_pc)
        else $error("acknowledge did not clear pin change flag");

    w1c_clear_a_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && wr_acc && wb_adr_i == EPI_OFS_FLAGS && wb_dat_i[EPI_BIT_A] && !ext_trig[0])
            |=> !st.flag_a)
        else $error("write one did not clear flag a");

    hi_group_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_req.irq_pc_hi |-> (pin_change_lines[15:8] != pin_change_ref[15:8]))
        else $error("upper group request without a toggle");

    lo_group_a: assert property (@(posedge clk) disable iff (!nrst)
        irq_req.irq_pc_lo |-> (pin_change_lines[7:0] != pin_change_ref[7:0]))
        else $error("lower group request without a toggle");

    wake_level_a: assert property (@(posedge clk) disable iff (!nrst)
        (st.en[EPI_BIT_A] && st.sense[1:0] == 2'b00 && !ext_line_a) |-> wake_req)
        else $error("held low level gives no wake");

    wake_pc_a: assert property (@(posedge clk) disable iff (!nrst)
        (st.en[EPI_BIT_PC] && pc_lo_change) |-> wake_req)
        else $error("enabled pin change gives no wake");

    freeze_a: assert property (@(posedge clk) disable iff (!nrst)
        !clk_en |=> $stable(st.flag_a) && $stable(st.ext_s1))
        else $error("state moved with clock enable low");

endmodule

`default_nettype wire

// >>> tb/epi_cpu_model.sv
// CPU side of the interrupt block: acknowledges a pending vector.
// Assumes the block's clock and reset; the bench drives the pins.
`timescale 1ns/100ps
`default_nettype none

module epi_cpu_model
    import epi_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     nrst,
    input  wire logic     ack_on,
    input  wire epi_req_t irq_req,
    output epi_iack_t     irq_ack
);
    // Vector runs the cycle after a request is seen; one-cycle pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_ack <= '0;
        end else begin
            irq_ack.ack_b  <= ack_on && irq_req.irq_b && !irq_ack.ack_b;
            irq_ack.ack_a  <= ack_on && irq_req.irq_a && !irq_ack.ack_a;
            irq_ack.ack_pc <= ack_on && irq_req.irq_pc && !irq_ack.ack_pc;
        end
    end
endmodule

`default_nettype wire

// >>> tb/external_pin_interrupts_tb.sv
// Self-checking bench of the external pin interrupt block.
// Assumes a classic Wishbone register map and the CPU model as acknowledger.
`timescale 1ns/100ps
`default_nettype none

module external_pin_interrupts_tb
    import epi_pkg::*;
;
    logic        clk, nrst, cyc, stb, we, ack, la, lb, gie, ack_on, wake, ce;
    logic [3:0]  adr;
    logic [31:0] dat, dat_o, q;
    logic [15:0] pcl, pcr;
    logic [7:0]  mhi;
    epi_iack_t   iack;
    epi_req_t    req;
    int          fail_count, samples_checked;

    epi_ext_irq uut (.clk(clk), .nrst(nrst), .clk_en(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .ext_line_a(la), .ext_line_b(lb), .pin_change_lines(pcl),
        .pin_change_ref(pcr), .pin_change_mask_hi(mhi), .global_irq_en(gie),
        .irq_ack(iack), .irq_req(req), .wake_req(wake));
    epi_cpu_model cpu (.clk(clk), .nrst(nrst), .ack_on(ack_on), .irq_req(req), .irq_ack(iack));

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            final_report();
        end
    endtask

    // Waits n edges, then samples at the falling edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pin(input logic b, input logic v);
        @(posedge clk);
        if (b) lb <= v;
        else la <= v;
    endtask

    task automatic t_regs();
        bus(0, EPI_OFS_SENSE, 0); chk(q, 32'h0);
        bus(0, EPI_OFS_EN, 0); chk(q, 32'h0);
        bus(0, EPI_OFS_MASK, 0); chk(q, 32'h0);
        bus(1, EPI_OFS_EN, 32'hFF);
        bus(0, EPI_OFS_EN, 0); chk(q, 32'hE1);
        bus(1, EPI_OFS_MASK, 32'hA5);
        bus(0, EPI_OFS_MASK, 0); chk(q, 32'hA5);
        bus(1, 4'h2, 32'hFF);
        bus(0, 4'h2, 0); chk(q, 32'h0);
    endtask

    // Every edge code on one line; the opposite edge only counts in change mode
    task automatic t_edge(input logic b);
        logic v;
        int   f;
        f = b ? EPI_BIT_B : EPI_BIT_A;
        bus(1, EPI_OFS_EN, 32'h1 << f);
        for (int m = 1; m < 4; m++) begin
            v = (m == 2);
            pin(b, v);
            bus(1, EPI_OFS_SENSE, b ? m << 2 : m);
            settle(6);
            bus(1, EPI_OFS_FLAGS, 32'hE0);
            pin(b, !v);
            settle(6);
            chk(b ? req.irq_b : req.irq_a, 1);
            bus(0, EPI_OFS_FLAGS, 0); chk(q[f], 1);
            bus(1, EPI_OFS_FLAGS, 32'h1 << f);
            settle(0);
            chk(b ? req.irq_b : req.irq_a, 0);
            pin(b, v);
            settle(6);
            bus(0, EPI_OFS_FLAGS, 0); chk(q[f], m == 1);
        end
        bus(1, EPI_OFS_FLAGS, 32'hE0);
    endtask

    // Line held low through the first checks, then released high for the last
    task automatic t_level(input logic b);
        bus(1, EPI_OFS_SENSE, 0);
        bus(1, EPI_OFS_EN, b ? 32'h80 : 32'h40);
        pin(b, 0);
        settle(1);
        chk(b ? req.irq_b : req.irq_a, 1);
        chk(wake, 1);
        bus(0, EPI_OFS_FLAGS, 0); chk(q[7:5], 0);
        gie <= 1'b0;
        settle(1);
        chk(b ? req.irq_b : req.irq_a, 0);
        pin(b, 1);
        gie <= 1'b1;
        settle(1);
        chk(b ? req.irq_b : req.irq_a, 0);
    endtask

    task automatic t_pc();
        bus(1, EPI_OFS_EN, 32'h20);
        bus(1, EPI_OFS_MASK, 32'h01);
        @(posedge clk);
        pcl[1] <= 1'b1;
        settle(1);
        chk(req.irq_pc_lo, 0);
        @(posedge clk);
        pcl[0] <= 1'b1;
        settle(1);
        chk(req.irq_pc_lo, 1);
        chk(wake, 1);
        settle(3);
        chk(req.irq_pc, 1);
        bus(0, EPI_OFS_FLAGS, 0); chk(q[5], 1);
        pcr <= pcl;
        bus(1, EPI_OFS_FLAGS, 32'h20);
        bus(0, EPI_OFS_FLAGS, 0); chk(q[5], 0);
        chk(req.irq_pc, 0);
        mhi <= 8'h80;
        pcr <= pcl;
        pcl[14] <= 1'b1;
        settle(1);
        chk(req.irq_pc_hi, 0);
        @(posedge clk);
        pcl[15] <= 1'b1;
        settle(1);
        chk(req.irq_pc_hi, 1);
        pcr <= pcl;
        bus(1, EPI_OFS_FLAGS, 32'hE0);
    endtask

    // A rising edge arriving while the clock enable is low waits until it returns
    task automatic t_ce();
        bus(1, EPI_OFS_SENSE, 32'h3);
        bus(1, EPI_OFS_EN, 32'h40);
        pin(0, 0);
        settle(4);
        bus(1, EPI_OFS_FLAGS, 32'hE0);
        @(posedge clk);
        ce <= 1'b0;
        la <= 1'b1;
        settle(6);
        chk(req.irq_a, 0);
        @(posedge clk);
        ce <= 1'b1;
        settle(6);
        chk(req.irq_a, 1);
        bus(1, EPI_OFS_FLAGS, 32'hE0);
    endtask

    // The CPU model acknowledges; the flag must clear by itself
    task automatic t_ack();
        bus(1, EPI_OFS_EN, 32'h40);
        bus(1, EPI_OFS_SENSE, 32'h3);
        ack_on <= 1'b1;
        pin(0, 0);
        settle(4);
        pin(0, 1);
        settle(8);
        chk(req.irq_a, 0);
        bus(0, EPI_OFS_FLAGS, 0); chk(q[6], 0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {nrst, cyc, stb, we, la, lb, ack_on} = '0;
        {adr, dat, pcl, pcr, mhi} = '0;
        gie = 1'b1;
        ce = 1'b1;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_edge(0);
        t_edge(1);
        t_level(0);
        t_level(1);
        t_pc();
        t_ce();
        t_ack();
        final_report();
    end
endmodule

`default_nettype wire
